// file: uies_core.v
// Purpose: interrupt masking, prioritised cause and line state for a serial port
// Assumes: receive/transmit datapath supplies level status and one-cycle events
// Notes:   all status pins synchronous to i_clk except cts, which is synchronised
`include "uies_consts.vh"

module uies_core
(
	input  wire                    i_clk,
	input  wire                    i_rst_b,
	input  wire                    i_ce,
	input  wire [`UIES_ADDR_W-1:0] i_addr,
	input  wire [7:0]              i_wdata,
	input  wire                    i_wr,
	input  wire                    i_rd,
	input  wire                    i_rx_avail,
	input  wire                    i_rx_trig,
	input  wire                    i_rx_push,
	input  wire                    i_rx_pop,
	input  wire                    i_rx_overrun,
	input  wire [2:0]              i_push_err,
	input  wire [2:0]              i_head_err,
	input  wire                    i_fifo_err,
	input  wire                    i_tx_hold_empty,
	input  wire                    i_tx_trig,
	input  wire                    i_tx_all_empty,
	input  wire [3:0]              i_modem_delta,
	input  wire                    i_char_match,
	input  wire                    i_xoff_match,
	input  wire                    i_rts_out,
	input  wire                    i_cts_pin,
	input  wire                    i_wake,
	input  wire [`UIES_DIV_W-1:0]  i_bit_div,
	output reg  [7:0]              o_rdata,
	output reg                     o_irq,
	output reg                     o_sleep,
	output reg                     o_fifo_en
);

	reg  [7:0]             mask_q;
	reg  [7:0]             feat_q;
	reg  [7:0]             mode_q;
	reg  [3:0]             modem_q;
	reg                    ovr_q;
	reg  [2:0]             err_q;
	reg                    lsi_q;
	reg                    txi_q;
	reg                    tmo_q;
	reg                    chr_q;
	reg                    flow_q;
	reg                    wake_q;
	reg                    tx_empty_q;
	reg                    rts_q;
	reg                    cts_s1_q;
	reg                    cts_s2_q;
	reg                    cts_q;
	reg  [5:0]             held_q;
	reg  [`UIES_DIV_W-1:0] div_q;
	reg  [`UIES_TMO_W-1:0] tmo_cnt_q;
	reg  [5:0]             cause_d;
	reg  [7:0]             rdata_d;

	wire       fifo_on   = mode_q[`UIES_MODE_FIFO];
	wire       enh       = feat_q[`UIES_FEAT_ENH];
	wire       rd_mask   = i_rd && (i_addr == `UIES_OFF_MASK);
	wire       rd_cause  = i_rd && (i_addr == `UIES_OFF_CAUSE);
	wire       rd_line   = i_rd && (i_addr == `UIES_OFF_LINE);
	wire       rd_modem  = i_rd && (i_addr == `UIES_OFF_MODEM);
	wire       wr_mask   = i_wr && (i_addr == `UIES_OFF_MASK);
	wire       wr_tx     = i_wr && (i_addr == `UIES_OFF_TXHOLD);
	wire [2:0] err_sel   = mode_q[`UIES_MODE_ERR_ON_ENTRY] ? i_push_err : i_head_err;
	wire       err_ev    = mode_q[`UIES_MODE_ERR_ON_ENTRY] ? (i_rx_push && |i_push_err) : (|i_head_err);
	wire       rx_src    = fifo_on ? i_rx_trig : i_rx_avail;
	wire       tx_src    = fifo_on ? i_tx_trig : i_tx_hold_empty;
	wire       tx_rise   = tx_src && !tx_empty_q;
	wire       tx_arm    = wr_mask && i_wdata[1] && !mask_q[1] && tx_src;
	wire       rts_rise  = i_rts_out && !rts_q && feat_q[`UIES_FEAT_ARTS];
	wire       cts_rise  = cts_s2_q && !cts_q && feat_q[`UIES_FEAT_ACTS];
	wire       p_line    = mask_q[2] && lsi_q;
	wire       p_tmo     = mask_q[0] && tmo_q;
	wire       p_rx      = mask_q[0] && rx_src;
	wire       p_tx      = mask_q[1] && txi_q;
	wire       p_modem   = mask_q[3] && |modem_q;
	wire       p_chr     = enh && mask_q[5] && chr_q;
	wire       p_flow    = enh && (mask_q[6] || mask_q[7]) && flow_q;
	wire       p_wake    = enh && wake_q;
	wire       any_pend  = p_line | p_tmo | p_rx | p_tx | p_modem | p_chr | p_flow | p_wake;
	wire       polled    = fifo_on && (mask_q[3:0] == 4'h0);
	// product kept at counter width so no bits are dropped silently
	localparam [7:0] TMO_CHARS = 4 * `UIES_CHAR_BITS + `UIES_TMO_BITS;
	wire [`UIES_TMO_W-1:0] tmo_lim = {8'h00, i_bit_div} * {16'h0000, TMO_CHARS};

	// fixed priority, line status highest
	always @*
	begin
		if (p_line)
			cause_d = `UIES_CAUSE_LINE;
		else if (p_tmo)
			cause_d = `UIES_CAUSE_TMO;
		else if (p_rx)
			cause_d = `UIES_CAUSE_RX_AVAIL_EVENT;
		else if (p_tx)
			cause_d = `UIES_CAUSE_TX_SPACE_EVENT;
		else if (p_modem)
			cause_d = `UIES_CAUSE_MODEM;
		else if (p_chr)
			cause_d = `UIES_CAUSE_CHAR;
		else if (p_flow)
			cause_d = `UIES_CAUSE_FLOW;
		else
			cause_d = `UIES_CAUSE_NONE;
	end

	// held cause is kept while its source still pends so all others wait, higher ones too
	wire held_live = (held_q == `UIES_CAUSE_LINE  && p_line)  ||
	                 (held_q == `UIES_CAUSE_TMO   && p_tmo)   ||
	                 (held_q == `UIES_CAUSE_RX_AVAIL_EVENT && p_rx)    ||
	                 (held_q == `UIES_CAUSE_TX_SPACE_EVENT && p_tx)    ||
	                 (held_q == `UIES_CAUSE_MODEM && p_modem) ||
	                 (held_q == `UIES_CAUSE_CHAR  && p_chr)   ||
	                 (held_q == `UIES_CAUSE_FLOW  && p_flow);
	wire [5:0] cause_now = held_live ? held_q : cause_d;

	always @*
	begin
		rdata_d = 8'h00;
		if (rd_mask)
			rdata_d = mask_q;
		else if (rd_cause)
			rdata_d = {{2{fifo_on}}, cause_now};
		else if (rd_line)
			rdata_d = {fifo_on & i_fifo_err, i_tx_all_empty, i_tx_hold_empty, err_sel, ovr_q, i_rx_avail};
		else if (rd_modem)
			rdata_d = {4'h0, modem_q};
		else if (i_rd && i_addr == `UIES_OFF_FEATURES)
			rdata_d = feat_q;
		else if (i_rd && i_addr == `UIES_OFF_MODE)
			rdata_d = mode_q;
	end

	always @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			mask_q     <= `UIES_MASK_RESET;
			feat_q     <= `UIES_FEAT_RESET;
			mode_q     <= `UIES_MODE_RESET;
			modem_q    <= 4'h0;
			ovr_q      <= 1'b0;
			err_q      <= 3'h0;
			lsi_q      <= 1'b0;
			txi_q      <= 1'b0;
			tmo_q      <= 1'b0;
			chr_q      <= 1'b0;
			flow_q     <= 1'b0;
			wake_q     <= 1'b0;
			tx_empty_q <= 1'b0;
			rts_q      <= 1'b0;
			cts_s1_q   <= 1'b0;
			cts_s2_q   <= 1'b0;
			cts_q      <= 1'b0;
			held_q     <= `UIES_CAUSE_NONE;
			div_q      <= {`UIES_DIV_W{1'b0}};
			tmo_cnt_q  <= {`UIES_TMO_W{1'b0}};
			o_rdata    <= 8'h00;
			o_irq      <= 1'b0;
			o_sleep    <= 1'b0;
			o_fifo_en  <= 1'b0;
		end
		else if (i_ce)
		begin
			cts_s1_q   <= i_cts_pin;
			cts_s2_q   <= cts_s1_q;
			cts_q      <= cts_s2_q;
			rts_q      <= i_rts_out;
			tx_empty_q <= tx_src;
			o_rdata    <= rdata_d;
			if (wr_mask)
			begin
				mask_q[3:0] <= i_wdata[3:0];
				if (enh)
					mask_q[7:4] <= i_wdata[7:4];
			end
			if (i_wr && i_addr == `UIES_OFF_FEATURES)
				feat_q <= i_wdata;
			if (i_wr && i_addr == `UIES_OFF_MODE)
				mode_q <= i_wdata;
			// sticky flags (err_q excepted, it follows err_sel): set wins over a clearing read
			modem_q <= (rd_modem ? 4'h0 : modem_q) | i_modem_delta;
			ovr_q   <= (rd_line ? 1'b0 : ovr_q) | i_rx_overrun;
			err_q   <= err_sel;
			lsi_q   <= (rd_line ? 1'b0 : lsi_q) | i_rx_overrun | err_ev;
			txi_q   <= ((rd_cause || wr_tx) ? 1'b0 : txi_q) | tx_rise | tx_arm;
			chr_q   <= (rd_cause ? 1'b0 : chr_q) | i_char_match | (mask_q[5] & i_xoff_match);
			flow_q  <= (rd_modem ? 1'b0 : flow_q) | (mask_q[6] & rts_rise) | (mask_q[7] & cts_rise);
			wake_q  <= (rd_cause ? 1'b0 : wake_q) | (i_wake & o_sleep & mode_q[`UIES_MODE_WAKE]);
			if (rd_cause)
				held_q <= cause_now;
			else if (!held_live)
				held_q <= `UIES_CAUSE_NONE;
			// time-out counts clock cycles, up to i_bit_div times 52, while data waits unread in FIFO mode
			if (i_rx_push || i_rx_pop || !i_rx_avail || !fifo_on)
			begin
				tmo_cnt_q <= {`UIES_TMO_W{1'b0}};
				div_q     <= {`UIES_DIV_W{1'b0}};
				if (i_rx_pop || !i_rx_avail)
					tmo_q <= 1'b0;
			end
			else
			begin
				div_q <= div_q + 1'b1;
				if (tmo_cnt_q < tmo_lim)
					tmo_cnt_q <= tmo_cnt_q + 1'b1;
				else
					tmo_q <= 1'b1;
			end
			o_sleep   <= mask_q[4] & enh & ~i_wake;
			o_fifo_en <= fifo_on;
			o_irq     <= any_pend & ~polled;
		end
	end

endmodule

// file: uies_consts.vh
// Purpose: constants for the interrupt mask and status block
// Assumes: one aligned register per address index, 8-bit data
// Notes:   all offsets are register indices
`ifndef UIES_CONSTS_VH
`define UIES_CONSTS_VH
`define UIES_ADDR_W            4
`define UIES_OFF_MASK          4'h1
`define UIES_OFF_CAUSE         4'h2
`define UIES_OFF_FEATURES      4'h3
`define UIES_OFF_LINE          4'h5
`define UIES_OFF_MODEM         4'h6
`define UIES_OFF_MODE          4'h7
`define UIES_OFF_TXHOLD        4'h0
`define UIES_MASK_RESET        8'h00
`define UIES_FEAT_RESET        8'h00
`define UIES_MODE_RESET        8'h00
`define UIES_FEAT_ENH          4
`define UIES_FEAT_ARTS         6
`define UIES_FEAT_ACTS         7
`define UIES_MODE_FIFO         0
`define UIES_MODE_WAKE         1
`define UIES_MODE_ERR_ON_ENTRY 6
`define UIES_CAUSE_LINE        6'h06
`define UIES_CAUSE_TMO         6'h0c
`define UIES_CAUSE_RX_AVAIL_EVENT       6'h04
`define UIES_CAUSE_TX_SPACE_EVENT       6'h02
`define UIES_CAUSE_MODEM       6'h00
`define UIES_CAUSE_CHAR        6'h10
`define UIES_CAUSE_FLOW        6'h20
`define UIES_CAUSE_NONE        6'h01
`define UIES_BIT_NS            40
`define UIES_TMO_BITS          12
`define UIES_CHAR_BITS         10
`define UIES_DIV_W             16
`define UIES_TMO_W             24
`endif

// file: uies_core_sva.sv
// Purpose: port checks for uies_core
// Assumes: one clock, mask mirror from bus writes
// Notes:   only mask bits 3:0 mirrored, upper ones may be locked
`include "uies_consts.vh"
module uies_core_sva
(
	input wire                    i_clk,
	input wire                    i_rst_b,
	input wire                    i_ce,
	input wire [`UIES_ADDR_W-1:0] i_addr,
	input wire [7:0]              i_wdata,
	input wire                    i_wr,
	input wire                    i_rd,
	input wire                    i_rx_avail,
	input wire                    i_rx_overrun,
	input wire                    i_tx_hold_empty,
	input wire [3:0]              i_modem_delta,
	input wire [7:0]              o_rdata,
	input wire                    o_irq,
	input wire                    o_sleep,
	input wire                    o_fifo_en
);
	logic [3:0] mask_q;
	logic       feat_q;
	wire        polled = o_fifo_en && mask_q == 4'h0;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			mask_q <= 4'h0;
			feat_q <= 1'b0;
		end
		else if (i_ce && i_wr && i_addr == `UIES_OFF_MASK)
			mask_q <= i_wdata[3:0];
		else if (i_ce && i_wr && i_addr == `UIES_OFF_FEATURES)
			feat_q <= i_wdata[`UIES_FEAT_ENH];
	end
	a_ready_flag: assert property (i_ce && i_rd && i_addr == `UIES_OFF_LINE |=>
		o_rdata[0] == $past(i_rx_avail) && o_rdata[5] == $past(i_tx_hold_empty)) else $error("line bits wrong");
	a_fifo_mode: assert property (i_ce && i_wr && i_addr == `UIES_OFF_MODE |=> ##1
		o_fifo_en == $past(i_wdata[0], 2)) else $error("fifo enable wrong");
	a_polled_quiet: assert property (polled [*3] |-> !o_irq) else $error("irq in polled mode");
	a_tx_now: assert property ($rose(mask_q[1]) && i_tx_hold_empty && !o_fifo_en |->
		##[0:3] o_irq) else $error("tx ready late");
	a_modem_raise: assert property (i_ce && i_modem_delta != 4'h0 && mask_q[3] |->
		##[1:3] o_irq) else $error("modem irq missing");
	a_overrun_raise: assert property (i_ce && i_rx_overrun && mask_q[2] |->
		##[1:3] o_irq) else $error("overrun irq missing");
	a_sleep_lock: assert property (i_ce && i_wr && i_addr == `UIES_OFF_MASK && !feat_q |=> ##1
		!$rose(o_sleep)) else $error("sleep set while locked");
	a_cause_pend: assert property (i_ce && i_rd && i_addr == `UIES_OFF_CAUSE && o_irq && !$past(i_rd) |=>
		!o_rdata[0]) else $error("pending cause bit 0 high");
endmodule
bind uies_core uies_core_sva u_sva (.*);

// file: uies_host.sv
// Purpose: host model driving the register port
// Assumes: one transfer per call
// Notes:   released address and data lines show inverted values to catch late sampling
module uies_host
(
	input  wire        i_clk,
	output logic [3:0] o_addr,
	output logic [7:0] o_wdata,
	output logic       o_wr,
	output logic       o_rd
);
	initial
		{o_addr, o_wdata, o_wr, o_rd} = 14'h0;
	task xfer(input [3:0] a, input [7:0] d, input w);
	begin
		@(posedge i_clk);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= w;
		o_rd    <= !w;
		@(posedge i_clk);
		o_addr  <= ~a;
		o_wdata <= ~d;
		o_wr    <= 1'b0;
		o_rd    <= 1'b0;
	end
	endtask
endmodule

// file: uart_interrupt_enable_status_tb_top.sv
// Purpose: self-checking bench for uies_core
// Assumes: host model makes every register access
// Notes:   small bit divider shortens the time-out
`include "uies_consts.vh"
module uart_interrupt_enable_status_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam [3:0] LN = `UIES_OFF_LINE, CA = `UIES_OFF_CAUSE, MK = `UIES_OFF_MASK, MD = `UIES_OFF_MODE;
	logic        clk, rst_b, rav, trig, push, pop, ovr, hold, alle, ferr, wake, ttrig, rd_v;
	logic [2:0]  perr, herr;
	logic [3:0]  mdel;
	logic [15:0] div, e;
	logic [15:0] expq[$];
	logic [31:0] seed, r;
	wire  [3:0]  addr;
	wire  [7:0]  wdata, rdata;
	wire         wr, rd, irq, sleep, fifo_en;
	int          fail_count, check_count;
	uies_host HOST (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	uies_core DUT (.i_clk(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .i_rx_avail(rav), .i_rx_trig(trig), .i_rx_push(push), .i_rx_pop(pop), .i_rx_overrun(ovr),
		.i_push_err(perr), .i_head_err(herr), .i_fifo_err(ferr), .i_tx_hold_empty(hold), .i_tx_trig(ttrig),
		.i_tx_all_empty(alle), .i_modem_delta(mdel), .i_char_match(1'b0), .i_xoff_match(1'b0),
		.i_rts_out(1'b0), .i_cts_pin(1'b0), .i_wake(wake), .i_bit_div(div), .o_rdata(rdata), .o_irq(irq),
		.o_sleep(sleep), .o_fifo_en(fifo_en));
	task check(input [7:0] seen, input [7:0] exp);
	begin
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task rd_exp(input [3:0] a, input [7:0] m, input [7:0] x);
	begin
		expq.push_back({m, x});
		HOST.xfer(a, 8'h00, 1'b0);
	end
	endtask
	task wrap_up;
	begin
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	end
	endtask
	always @(posedge clk)
	begin
		if (rd_v)
		begin
			e = expq.pop_front();
			check(rdata & e[15:8], e[7:0]);
		end
		rd_v <= rd;
	end
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial
	begin
		#200000;
		fail_count++;
		wrap_up;
	end
	initial
	begin
		seed = 32'h6705e2db;
		{rst_b, rav, trig, push, pop, ovr, hold, alle, ferr, wake, ttrig, rd_v, perr, herr, mdel} = 22'h0;
		div = 16'hffff;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		rd_exp(MK, 8'hff, `UIES_MASK_RESET);
		rd_exp(CA, 8'hff, 8'h01);
		rd_exp(4'h4, 8'hff, 8'h00);
		HOST.xfer(MK, 8'hf0, 1'b1);
		rd_exp(MK, 8'hff, 8'h00);
		HOST.xfer(`UIES_OFF_FEATURES, 8'h10, 1'b1);
		HOST.xfer(MK, 8'h10, 1'b1);
		@(posedge clk);
		@(negedge clk);
		check(sleep, 8'h01);
		rd_exp(MK, 8'hff, 8'h10);
		HOST.xfer(MD, 8'h01, 1'b1);
		HOST.xfer(MK, 8'h00, 1'b1);
		repeat (4)
		begin
			r = $random(seed);
			{ttrig, wake, perr, rav, herr, hold, alle, ferr} <= r[11:0];
			rd_exp(LN, 8'hff, {r[0], r[1], r[2], r[5:3], 1'b0, r[6]});
		end
		{ttrig, wake, perr, rav, herr, hold, alle, ferr} <= 12'h0;
		@(posedge clk);
		ovr <= 1'b1;
		@(posedge clk);
		ovr <= 1'b0;
		rd_exp(LN, 8'hff, 8'h02);
		rd_exp(LN, 8'hff, 8'h00);
		HOST.xfer(MD, 8'h00, 1'b1);
		hold <= 1'b1;
		HOST.xfer(MK, 8'h02, 1'b1);
		repeat (3) @(posedge clk);
		rd_exp(CA, 8'hff, 8'h02);
		rd_exp(CA, 8'hff, 8'h01);
		@(negedge clk);
		check(irq, 8'h00);
		hold <= 1'b0;
		HOST.xfer(MK, 8'h0f, 1'b1);
		mdel <= 4'h5;
		ovr <= 1'b1;
		@(posedge clk);
		mdel <= 4'h0;
		ovr <= 1'b0;
		repeat (2) @(posedge clk);
		rd_exp(CA, 8'hff, 8'h06);
		rd_exp(LN, 8'hff, 8'h02);
		rd_exp(CA, 8'hff, 8'h00);
		rd_exp(`UIES_OFF_MODEM, 8'h0f, 8'h05);
		rd_exp(CA, 8'hff, 8'h01);
		div <= 16'h0002;
		HOST.xfer(MD, 8'h01, 1'b1);
		HOST.xfer(MK, 8'h01, 1'b1);
		{rav, trig, push} <= 3'h7;
		@(posedge clk);
		push <= 1'b0;
		repeat (2) @(posedge clk);
		rd_exp(CA, 8'hff, 8'hc4);
		trig <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(irq, 8'h00);
		repeat (130) @(posedge clk);
		rd_exp(CA, 8'hff, 8'hcc);
		{rav, pop} <= 2'h1;
		@(posedge clk);
		pop <= 1'b0;
		repeat (2) @(posedge clk);
		rd_exp(CA, 8'hff, 8'hc1);
		repeat (2) @(posedge clk);
		wrap_up;
	end
endmodule
